//--- hw/srpc_top.sv
// register bank for signal path resets, motion detect, buffer and power control
`timescale 1ns/100ps
`default_nettype none
`include "srpc_consts.svh"

// What this block does
// - writing one to signal-path bit 1 resets the acceleration path
// - writing one to signal-path bit 0 resets the temperature path
// - single path resets leave sensor output registers untouched
// - motion control bit 7 enables wake-on-motion detection
// - compare mode 0 holds the first sample, 1 uses the previous one
// - user control bit 6 enables buffer operation
// - clearing buffer enable blocks only serial access to the buffer
// - user control bit 4 disables the two-wire port, leaving SPI only
// - writing one to user control bit 2 resets the buffer asynchronously
// - buffer reset bit clears itself after one 20 MHz cycle
// - writing one to user control bit 0 resets both signal paths
// - the conditioning reset also clears all sensor output registers
// - power bit 7 resets internal registers to their defaults
// - device reset bit clears itself when the reset is done
// - power bit 6 puts the chip to sleep, default zero
module srpc_top
    import srpc_pkg::*;
#(
    parameter int SAMPLE_W = 48,
    parameter int CNT_W    = 8
)(
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic                wr_en,
    input  wire logic [7:0]          wr_addr,
    input  wire logic [7:0]          wr_data,
    input  wire logic                rd_en,
    input  wire logic [7:0]          rd_addr,
    output var  logic [7:0]          rd_data,
    output var  logic                rd_valid,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample_data,
    output var  logic                accel_path_rst,
    output var  logic                temp_path_rst,
    output var  logic                sensor_regs_clear,
    output var  logic                buffer_rst,
    output var  logic                buffer_serial_en,
    output var  logic                two_wire_port_disable,
    output var  logic                motion_detect_enable,
    output var  logic                motion_compare_mode,
    output var  logic [SAMPLE_W-1:0] motion_ref,
    output var  logic                motion_ref_valid,
    output var  logic                sleep_mode,
    output var  logic                device_regs_rst
);

    // pulse lengths in mclk cycles
    localparam int BUF_RST_CYC  = srpc_cycles(`SRPC_BUF_RST_NS);
    localparam int PATH_RST_CYC = srpc_cycles(`SRPC_PATH_RST_NS);
    localparam int DEV_RST_CYC  = srpc_cycles(`SRPC_DEV_RST_NS);

    // length of each pulse slot
    function automatic int pulse_len(input int idx);
        int len;
        len = PATH_RST_CYC;
        if (idx == `SRPC_PULSE_BUF)
            len = BUF_RST_CYC;
        else if (idx == `SRPC_PULSE_DEV)
            len = DEV_RST_CYC;
        return len;
    endfunction : pulse_len

    // stored register state
    srpc_byte_t          motion_q;
    srpc_byte_t          motion_d;
    srpc_byte_t          user_q;
    srpc_byte_t          user_d;
    srpc_byte_t          power_q;
    srpc_byte_t          power_d;

    // read port
    srpc_byte_t          rd_data_q;
    srpc_byte_t          rd_mux;
    logic                rd_valid_q;

    // output flops
    logic                accel_rst_q;
    logic                temp_rst_q;
    logic                sensor_clr_q;
    logic                buf_rst_q;
    logic                dev_rst_q;

    // motion reference tracking
    srpc_ref_state_t     ref_state_q;
    srpc_ref_state_t     ref_state_d;
    logic [SAMPLE_W-1:0] ref_q;
    logic [SAMPLE_W-1:0] ref_d;
    logic                ref_valid_q;

    // decode
    srpc_sel_t           wr_sel;
    srpc_sel_t           rd_sel;
    logic                wr_ok;
    logic                wr_sig_path;
    logic                wr_motion;
    logic                wr_user;
    logic                wr_power;
    logic                dev_start;
    logic                dev_busy;
    logic                path_flush;

    srpc_pulse_if pulse_bus [`SRPC_PULSE_N] ();

    // one timer per self-clearing bit
    for (genvar g = 0; g < `SRPC_PULSE_N; g++)
    begin : g_pulse
        srpc_pulse_gen #(
            .LEN (pulse_len(g)),
            .CW  (CNT_W)
        ) u_pulse (
            .mclk  (mclk),
            .rst_b (rst_b),
            .pulse (pulse_bus[g])
        );
    end

    // write decode; writes are dropped while the device reset runs
    assign wr_sel      = srpc_decode(wr_addr);
    assign rd_sel      = srpc_decode(rd_addr);
    assign dev_busy    = pulse_bus[`SRPC_PULSE_DEV].active;
    assign wr_ok       = wr_en && !dev_busy;
    assign wr_sig_path = wr_ok && (wr_sel == srpc_sel_sig_path);
    assign wr_motion   = wr_ok && (wr_sel == srpc_sel_motion);
    assign wr_user     = wr_ok && (wr_sel == srpc_sel_user);
    assign wr_power    = wr_ok && (wr_sel == srpc_sel_power);
    assign dev_start   = wr_power && wr_data[`SRPC_PM_DEV_RST_BIT];

    // starts of the self-clearing pulses
    assign pulse_bus[`SRPC_PULSE_ACCEL].start =
        wr_sig_path && wr_data[`SRPC_SP_ACCEL_BIT];
    assign pulse_bus[`SRPC_PULSE_TEMP].start =
        wr_sig_path && wr_data[`SRPC_SP_TEMP_BIT];
    assign pulse_bus[`SRPC_PULSE_COND].start =
        wr_user && wr_data[`SRPC_UC_COND_RST_BIT];
    assign pulse_bus[`SRPC_PULSE_BUF].start =
        wr_user && wr_data[`SRPC_UC_BUF_RST_BIT];
    assign pulse_bus[`SRPC_PULSE_DEV].start = dev_start;

    // next register values; the device reset overrides any other bit of its write
    assign motion_d = dev_start ? `SRPC_MD_RST :
                      wr_motion ? (wr_data & `SRPC_MD_WMASK) : motion_q;
    assign user_d   = dev_start ? `SRPC_UC_RST :
                      wr_user ? (wr_data & `SRPC_UC_WMASK) : user_q;
    assign power_d  = dev_start ? `SRPC_PM_RST :
                      wr_power ? (wr_data & `SRPC_PM_WMASK) : power_q;

    // stored control registers
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            motion_q <= `SRPC_MD_RST;
            user_q   <= `SRPC_UC_RST;
            power_q  <= `SRPC_PM_RST;
        end
        else
        begin
            motion_q <= motion_d;
            user_q   <= user_d;
            power_q  <= power_d;
        end
    end

    // read mux: self-clearing bits show one while their pulse still runs
    always_comb
    begin
        rd_mux = `SRPC_RD_ZERO;
        if (rd_sel == srpc_sel_sig_path)
        begin
            rd_mux[`SRPC_SP_ACCEL_BIT] = pulse_bus[`SRPC_PULSE_ACCEL].active;
            rd_mux[`SRPC_SP_TEMP_BIT]  = pulse_bus[`SRPC_PULSE_TEMP].active;
        end
        else if (rd_sel == srpc_sel_motion)
            rd_mux = motion_q;
        else if (rd_sel == srpc_sel_user)
        begin
            rd_mux = user_q;
            rd_mux[`SRPC_UC_BUF_RST_BIT]  = pulse_bus[`SRPC_PULSE_BUF].active;
            rd_mux[`SRPC_UC_COND_RST_BIT] = pulse_bus[`SRPC_PULSE_COND].active;
        end
        else if (rd_sel == srpc_sel_power)
        begin
            rd_mux = power_q;
            rd_mux[`SRPC_PM_DEV_RST_BIT] = dev_busy;
        end
    end

    // read data register, one cycle after the request; unmapped reads give zero
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            rd_data_q  <= `SRPC_RD_ZERO;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_data_q  <= rd_en ? rd_mux : rd_data_q;
            rd_valid_q <= rd_en;
        end
    end

    // reset outputs, registered so the neighbours see clean levels
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            accel_rst_q  <= 1'b0;
            temp_rst_q   <= 1'b0;
            sensor_clr_q <= 1'b0;
            buf_rst_q    <= 1'b0;
            dev_rst_q    <= 1'b0;
        end
        else
        begin
            accel_rst_q  <= pulse_bus[`SRPC_PULSE_ACCEL].active
                            || pulse_bus[`SRPC_PULSE_COND].active;
            temp_rst_q   <= pulse_bus[`SRPC_PULSE_TEMP].active
                            || pulse_bus[`SRPC_PULSE_COND].active;
            sensor_clr_q <= pulse_bus[`SRPC_PULSE_COND].active;
            buf_rst_q    <= pulse_bus[`SRPC_PULSE_BUF].active;
            dev_rst_q    <= dev_busy;
        end
    end

    // any reset of the acceleration path throws away the reference sample
    assign path_flush = pulse_bus[`SRPC_PULSE_ACCEL].active
                        || pulse_bus[`SRPC_PULSE_COND].active;

    // reference tracking: wait for the first sample, then hold it or follow
    always_comb
    begin
        ref_state_d = ref_state_q;
        ref_d       = ref_q;
        case (ref_state_q)
            srpc_ref_idle:
            begin
                if (motion_q[`SRPC_MD_EN_BIT])
                    ref_state_d = srpc_ref_wait;
            end
            srpc_ref_wait:
            begin
                if (sample_valid)
                begin
                    ref_d       = sample_data;
                    ref_state_d = srpc_ref_track;
                end
            end
            srpc_ref_track:
            begin
                if (sample_valid && motion_q[`SRPC_MD_MODE_BIT])
                    ref_d = sample_data;
            end
            default:
                ref_state_d = srpc_ref_idle;
        endcase
        // leaving the mode or an acceleration path reset starts over from the first sample
        if (!motion_q[`SRPC_MD_EN_BIT] || path_flush)
            ref_state_d = srpc_ref_idle;
    end

    // reference registers
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            ref_state_q <= srpc_ref_idle;
            ref_q       <= '0;
            ref_valid_q <= 1'b0;
        end
        else
        begin
            ref_state_q <= ref_state_d;
            ref_q       <= ref_d;
            ref_valid_q <= (ref_state_d == srpc_ref_track);
        end
    end

    // outputs straight from flops
    assign rd_data               = rd_data_q;
    assign rd_valid              = rd_valid_q;
    assign accel_path_rst        = accel_rst_q;
    assign temp_path_rst         = temp_rst_q;
    assign sensor_regs_clear     = sensor_clr_q;
    assign buffer_rst            = buf_rst_q; // used as an async reset by the buffer
    assign buffer_serial_en      = user_q[`SRPC_UC_BUF_EN_BIT];
    assign two_wire_port_disable = user_q[`SRPC_UC_TWP_DIS_BIT];
    assign motion_detect_enable  = motion_q[`SRPC_MD_EN_BIT];
    assign motion_compare_mode   = motion_q[`SRPC_MD_MODE_BIT];
    assign motion_ref            = ref_q;
    assign motion_ref_valid      = ref_valid_q;
    assign sleep_mode            = power_q[`SRPC_PM_SLEEP_BIT];
    assign device_regs_rst       = dev_rst_q;

    // motion bit 0 is stored and read back as written; keeping it zero while
    // detection runs is left to software, the block does not check it

endmodule : srpc_top

`default_nettype wire

//--- common/srpc_consts.svh
// constants of the sensor reset and power control block
`ifndef SRPC_CONSTS_SVH
`define SRPC_CONSTS_SVH

// register addresses on the serial register port
`define SRPC_ADDR_SIG_PATH   8'h68
`define SRPC_ADDR_MOTION     8'h69
`define SRPC_ADDR_USER       8'h6a
`define SRPC_ADDR_POWER      8'h6b

// field positions
`define SRPC_SP_ACCEL_BIT    1
`define SRPC_SP_TEMP_BIT     0
`define SRPC_MD_EN_BIT       7
`define SRPC_MD_MODE_BIT     6
`define SRPC_MD_RSV_BIT      0
`define SRPC_UC_BUF_EN_BIT   6
`define SRPC_UC_TWP_DIS_BIT  4
`define SRPC_UC_BUF_RST_BIT  2
`define SRPC_UC_COND_RST_BIT 0
`define SRPC_PM_DEV_RST_BIT  7
`define SRPC_PM_SLEEP_BIT    6

// bits that hold stored state; all others read zero, except self-clearing bits while their pulse runs
`define SRPC_MD_WMASK        8'hc1
`define SRPC_UC_WMASK        8'h50
`define SRPC_PM_WMASK        8'h40

// reset values
`define SRPC_MD_RST          8'h00
`define SRPC_UC_RST          8'h00
`define SRPC_PM_RST          8'h00
`define SRPC_RD_ZERO         8'h00

// timing: clock rate in kHz and pulse lengths in ns
`define SRPC_MCLK_KHZ        40000
`define SRPC_KHZ_NS_SCALE    1000000
`define SRPC_BUF_RST_NS      50
`define SRPC_PATH_RST_NS     100
`define SRPC_DEV_RST_NS      200

// self-clearing pulse slots
`define SRPC_PULSE_N         5
`define SRPC_PULSE_ACCEL     0
`define SRPC_PULSE_TEMP      1
`define SRPC_PULSE_COND      2
`define SRPC_PULSE_BUF       3
`define SRPC_PULSE_DEV       4

`endif

//--- common/srpc_pkg.sv
// types and helper functions of the sensor reset and power control block
`include "srpc_consts.svh"

package srpc_pkg;

    typedef logic [7:0] srpc_byte_t;

    // register selected by an address
    typedef enum logic [2:0] {
        srpc_sel_none,
        srpc_sel_sig_path,
        srpc_sel_motion,
        srpc_sel_user,
        srpc_sel_power
    } srpc_sel_t;

    // motion reference tracking states
    typedef enum logic [1:0] {
        srpc_ref_idle,
        srpc_ref_wait,
        srpc_ref_track
    } srpc_ref_state_t;

    // address decode, shared by the write and the read path
    function automatic srpc_sel_t srpc_decode(input srpc_byte_t addr);
        srpc_sel_t sel;
        sel = srpc_sel_none;
        if (addr == `SRPC_ADDR_SIG_PATH)
            sel = srpc_sel_sig_path;
        else if (addr == `SRPC_ADDR_MOTION)
            sel = srpc_sel_motion;
        else if (addr == `SRPC_ADDR_USER)
            sel = srpc_sel_user;
        else if (addr == `SRPC_ADDR_POWER)
            sel = srpc_sel_power;
        return sel;
    endfunction : srpc_decode

    // least time in ns to mclk cycles, rounded up, never below one
    function automatic int srpc_cycles(input int ns);
        int c;
        c = (ns * `SRPC_MCLK_KHZ + `SRPC_KHZ_NS_SCALE - 1) / `SRPC_KHZ_NS_SCALE;
        return (c < 1) ? 1 : c;
    endfunction : srpc_cycles

endpackage : srpc_pkg

//--- common/srpc_pulse_if.sv
// start and active pair between the register bank and a pulse timer
`timescale 1ns/100ps
`default_nettype none

interface srpc_pulse_if;
    logic start;
    logic active;
    modport gen  (input start, output active);
    modport user (output start, input active);
endinterface : srpc_pulse_if

`default_nettype wire

//--- hw/srpc_pulse_gen.sv
// self-clearing pulse timer: active for LEN cycles after each start
`timescale 1ns/100ps
`default_nettype none

module srpc_pulse_gen
    import srpc_pkg::*;
#(
    parameter int LEN = 1,
    parameter int CW  = 8
)(
    input  wire logic  mclk,
    input  wire logic  rst_b,
    srpc_pulse_if.gen  pulse
);

    localparam logic [CW-1:0] LEN_C  = CW'(LEN);
    localparam logic [CW-1:0] ZERO_C = '0;
    localparam logic [CW-1:0] ONE_C  = CW'(1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // a start while running restarts the count, so a new request is never lost
    assign cnt_d = pulse.start ? LEN_C :
                   (cnt_q != ZERO_C) ? cnt_q - ONE_C : ZERO_C;
    assign pulse.active = (cnt_q != ZERO_C);

    // count register
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            cnt_q <= ZERO_C;
        else
            cnt_q <= cnt_d;
    end

endmodule : srpc_pulse_gen

`default_nettype wire

//--- tb/srpc_top_props.sv
// concurrent checks on the ports of the register bank
`timescale 1ns/100ps
`default_nettype none

module srpc_top_props
    import srpc_pkg::*;
#(
    parameter int SAMPLE_W = 48,
    parameter int CNT_W    = 8
)(
    input wire logic                mclk,
    input wire logic                rst_b,
    input wire logic                wr_en,
    input wire logic [7:0]          wr_addr,
    input wire logic [7:0]          wr_data,
    input wire logic                rd_en,
    input wire logic [7:0]          rd_addr,
    input wire logic [7:0]          rd_data,
    input wire logic                rd_valid,
    input wire logic                sample_valid,
    input wire logic [SAMPLE_W-1:0] sample_data,
    input wire logic                accel_path_rst,
    input wire logic                temp_path_rst,
    input wire logic                sensor_regs_clear,
    input wire logic                buffer_rst,
    input wire logic                buffer_serial_en,
    input wire logic                two_wire_port_disable,
    input wire logic                motion_detect_enable,
    input wire logic                motion_compare_mode,
    input wire logic [SAMPLE_W-1:0] motion_ref,
    input wire logic                motion_ref_valid,
    input wire logic                sleep_mode,
    input wire logic                device_regs_rst
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // accepted writes per register; the device reset pulse drops writes
    logic [3:0] dev_left_q;
    wire logic wok  = wr_en & (dev_left_q == 4'h0);
    wire logic w_sp = wok & (wr_addr == 8'h68);
    wire logic w_md = wok & (wr_addr == 8'h69);
    wire logic w_uc = wok & (wr_addr == 8'h6a);
    wire logic w_pm = wok & (wr_addr == 8'h6b);
    wire logic quiet = ~wr_en & ~accel_path_rst & motion_detect_enable & motion_ref_valid;

    // device reset busy window, counted from the writing edge; the reset output
    // lags it by one cycle, so it cannot stand in for the drop window itself
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            dev_left_q <= 4'h0;
        else if (w_pm && wr_data[7])
            dev_left_q <= 4'h8;
        else if (dev_left_q != 4'h0)
            dev_left_q <= dev_left_q - 4'h1;
    end

    rd_reserved_a:
        assert property (rd_en && rd_addr == 8'h68 |=> rd_valid && rd_data[7:2] == 6'h00)
        else $error("read answer or reserved bits wrong");
    accel_reset_a:
        assert property (w_sp && wr_data[1] |=> ##1 accel_path_rst[*4] ##1 !accel_path_rst)
        else $error("accel path reset pulse wrong");
    temp_reset_a:
        assert property (w_sp && wr_data[0] |=> ##1 temp_path_rst[*4])
        else $error("temp path reset pulse wrong");
    cond_reset_a:
        assert property (w_uc && wr_data[0] |=> ##1 (accel_path_rst && temp_path_rst)[*4])
        else $error("conditioning reset pulse wrong");
    clear_source_a:
        assert property ($rose(sensor_regs_clear) |-> $past(w_uc && wr_data[0], 2))
        else $error("sensor clear without conditioning reset");
    buffer_reset_a:
        assert property (w_uc && wr_data[2] |=> ##1 buffer_rst[*2])
        else $error("buffer reset pulse wrong");
    motion_ctrl_a:
        assert property (w_md |=> motion_detect_enable == $past(wr_data[7])
                         && motion_compare_mode == $past(wr_data[6]))
        else $error("motion control bits wrong");
    user_ctrl_a:
        assert property (w_uc |=> buffer_serial_en == $past(wr_data[6])
                         && two_wire_port_disable == $past(wr_data[4]))
        else $error("user control bits wrong");
    sleep_ctrl_a:
        assert property (w_pm && !wr_data[7] |=> sleep_mode == $past(wr_data[6]))
        else $error("sleep bit wrong");
    device_reset_a:
        assert property (w_pm && wr_data[7] |=> ##1 (device_regs_rst && !sleep_mode
                         && !motion_detect_enable)[*8] ##1 !device_regs_rst)
        else $error("device reset pulse wrong");
    ref_follow_a:
        assert property (quiet && motion_compare_mode && sample_valid
                         |=> motion_ref == $past(sample_data))
        else $error("reference not following samples");
    ref_hold_a:
        assert property (quiet && !motion_compare_mode |=> $stable(motion_ref))
        else $error("reference not held");
endmodule : srpc_top_props

bind srpc_top srpc_top_props #(.SAMPLE_W(SAMPLE_W), .CNT_W(CNT_W)) u_props (
    .mclk(mclk), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .accel_path_rst(accel_path_rst), .temp_path_rst(temp_path_rst),
    .sensor_regs_clear(sensor_regs_clear), .buffer_rst(buffer_rst),
    .buffer_serial_en(buffer_serial_en), .two_wire_port_disable(two_wire_port_disable),
    .motion_detect_enable(motion_detect_enable), .motion_compare_mode(motion_compare_mode),
    .motion_ref(motion_ref), .motion_ref_valid(motion_ref_valid),
    .sleep_mode(sleep_mode), .device_regs_rst(device_regs_rst)
);

`default_nettype wire

//--- tb/srpc_host_model.sv
// host side model: register writes, reads and sensor samples
`timescale 1ns/100ps
`default_nettype none

module srpc_host_model #(
    parameter int SAMPLE_W = 48
)(
    input  wire logic                mclk,
    output var  logic                wr_en,
    output var  logic [7:0]          wr_addr,
    output var  logic [7:0]          wr_data,
    output var  logic                rd_en,
    output var  logic [7:0]          rd_addr,
    input  wire logic [7:0]          rd_data,
    input  wire logic                rd_valid,
    output var  logic                sample_valid,
    output var  logic [SAMPLE_W-1:0] sample_data
);
    // idle bus at time zero
    initial
    begin
        wr_en        = 1'b0;
        wr_addr      = 8'h00;
        wr_data      = 8'h00;
        rd_en        = 1'b0;
        rd_addr      = 8'h00;
        sample_valid = 1'b0;
        sample_data  = '0;
    end

    // released lines show inverted data so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_en   <= 1'b1;
        wr_addr <= a;
        wr_data <= (a == 8'h69 && d[7]) ? {d[7:1], 1'b0} : d;
        @(posedge mclk);
        wr_en   <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask : wr

    // bounded wait for the answer; ok stays low when none came
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int i;
        @(posedge mclk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge mclk);
        rd_en   <= 1'b0;
        rd_addr <= ~a;
        ok = 1'b0;
        d  = 8'h00;
        for (i = 0; i < 4 && !ok; i++)
        begin
            @(posedge mclk);
            ok = (rd_valid === 1'b1);
            d  = rd_data;
        end
    endtask : rd

    task automatic smp(input logic [SAMPLE_W-1:0] s);
        @(posedge mclk);
        sample_valid <= 1'b1;
        sample_data  <= s;
        @(posedge mclk);
        sample_valid <= 1'b0;
        sample_data  <= ~s;
    endtask : smp
endmodule : srpc_host_model

`default_nettype wire

//--- tb/srpc_top_test.sv
// self-checking bench of the register bank
`timescale 1ns/100ps
`default_nettype none

module srpc_top_test;
    logic mclk, rst_b, wr_en, rd_en, rd_valid, sample_valid;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    logic [47:0] sample_data, motion_ref;
    logic accel_path_rst, temp_path_rst, sensor_regs_clear, buffer_rst, buffer_serial_en;
    logic two_wire_port_disable, motion_detect_enable, motion_compare_mode;
    logic motion_ref_valid, sleep_mode, device_regs_rst;
    int n_fail = 0;
    int check_count = 0;

    srpc_top i_dut (.*);
    srpc_host_model h (.*);

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic results();
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // register read with a bounded wait; no answer ends the run
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        h.rd(a, d, ok);
        chk("rd_valid", 1, ok);
        if (!ok)
            results();
        else
            chk("rd_data", e, d);
    endtask : rdc

    task automatic t_defaults();
        logic [7:0] a;
        for (a = 8'h68; a <= 8'h6c; a++)
            rdc(a, 8'h00);
        chk("sleep_mode", 0, sleep_mode);
    endtask : t_defaults

    task automatic t_paths();
        h.wr(8'h68, 8'h02);
        @(posedge mclk);
        #1;
        chk("accel_rst", 1, accel_path_rst);
        chk("temp_rst", 0, temp_path_rst);
        chk("regs_clear", 0, sensor_regs_clear);
        rdc(8'h68, 8'h02);
        @(posedge mclk);
        #1;
        chk("accel_rst", 0, accel_path_rst);
        h.wr(8'h68, 8'hfd);
        @(posedge mclk);
        #1;
        chk("temp_rst", 1, temp_path_rst);
        chk("accel_rst", 0, accel_path_rst);
        chk("regs_clear", 0, sensor_regs_clear);
    endtask : t_paths

    task automatic t_cond();
        h.wr(8'h6a, 8'h01);
        @(posedge mclk);
        #1;
        chk("accel_rst", 1, accel_path_rst);
        chk("temp_rst", 1, temp_path_rst);
        chk("regs_clear", 1, sensor_regs_clear);
        rdc(8'h6a, 8'h01);
        repeat (2) @(posedge mclk);
        #1;
        chk("regs_clear", 0, sensor_regs_clear);
    endtask : t_cond

    task automatic t_user();
        h.wr(8'h6a, 8'hf4);
        @(posedge mclk);
        #1;
        chk("buf_rst", 1, buffer_rst);
        chk("buf_en", 1, buffer_serial_en);
        chk("twp_dis", 1, two_wire_port_disable);
        repeat (2) @(posedge mclk);
        #1;
        chk("buf_rst", 0, buffer_rst);
        rdc(8'h6a, 8'h50);
        h.wr(8'h6a, 8'h00);
        #1;
        chk("buf_en", 0, buffer_serial_en);
        chk("twp_dis", 0, two_wire_port_disable);
    endtask : t_user

    task automatic t_motion();
        h.wr(8'h69, 8'hff);
        #1;
        chk("md_en", 1, motion_detect_enable);
        chk("md_mode", 1, motion_compare_mode);
        h.smp(48'h0123_4567_89ab);
        #1;
        chk("ref", 48'h0123_4567_89ab, motion_ref);
        chk("ref_valid", 1, motion_ref_valid);
        h.smp(48'hfedc_ba98_7654);
        #1;
        chk("ref", 48'hfedc_ba98_7654, motion_ref);
        rdc(8'h69, 8'hc0);
        h.wr(8'h69, 8'h00);
        @(posedge mclk);
        #1;
        chk("ref_valid", 0, motion_ref_valid);
        h.wr(8'h69, 8'h80);
        h.smp(48'h5555_aaaa_3333);
        h.smp(48'h1111_2222_4444);
        #1;
        chk("ref", 48'h5555_aaaa_3333, motion_ref);
    endtask : t_motion

    task automatic t_device();
        h.wr(8'h6b, 8'h40);
        #1;
        chk("sleep", 1, sleep_mode);
        h.wr(8'h6b, 8'hc0);
        @(posedge mclk);
        #1;
        chk("dev_rst", 1, device_regs_rst);
        chk("sleep", 0, sleep_mode);
        chk("md_en", 0, motion_detect_enable);
        rdc(8'h6b, 8'h80);
        h.wr(8'h69, 8'h80);
        repeat (8) @(posedge mclk);
        #1;
        chk("dev_rst", 0, device_regs_rst);
        chk("md_en", 0, motion_detect_enable);
        rdc(8'h6b, 8'h00);
    endtask : t_device

    initial
    begin
        rst_b = 1'b0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_defaults();
        t_paths();
        t_cond();
        t_user();
        t_motion();
        t_device();
        results();
    end
endmodule : srpc_top_test

`default_nettype wire
